// file: wiper_pkg.sv
// Shared constants and types for the wiper position link: both ends and the testbench.
// Assumes a 40 MHz system clock on the controller end.
package wiper_pkg;
    localparam int unsigned WIPER_W        = 7;
    localparam int unsigned TAPS           = 128;
    localparam logic [6:0]  WIPER_RESET    = 7'h40;
    localparam logic [7:0]  REG_ADDR_WIPER = 8'h00;
    // Target identifier; the value is arbitrary.
    localparam logic [6:0]  DEVICE_ID      = 7'h2a;
    localparam logic [2:0]  BIT_LAST       = 3'h7;

    // Controller timing: one SCL period is four quarters.
    localparam int unsigned CLK_PERIOD_NS  = 25;
    localparam int unsigned SCL_QUARTER_NS = 1250;
    localparam int unsigned QUARTER_CYC    = (SCL_QUARTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [5:0]  QUARTER_LAST   = 6'(QUARTER_CYC - 1);

    // Controller register offsets and fields.
    localparam logic [11:0] CTRL_OFF       = 12'h000;
    localparam logic [11:0] STATUS_OFF     = 12'h004;
    localparam logic [11:0] TARGET_OFF     = 12'h008;
    localparam int unsigned CTRL_GO        = 0;
    localparam int unsigned CTRL_READ      = 1;
    localparam int unsigned CTRL_DATA_LSB  = 8;
    localparam int unsigned STAT_BUSY      = 0;
    localparam int unsigned STAT_DONE      = 1;
    localparam int unsigned STAT_NACK      = 2;
    localparam int unsigned STAT_RDATA_LSB = 8;

    typedef enum logic [8:0] {
        TGT_IDLE     = 9'h001,
        TGT_ADDR     = 9'h002,
        TGT_ACK_ADDR = 9'h004,
        TGT_REG      = 9'h008,
        TGT_ACK_REG  = 9'h010,
        TGT_DATA     = 9'h020,
        TGT_ACK_DATA = 9'h040,
        TGT_TX       = 9'h080,
        TGT_TX_ACK   = 9'h100
    } tgt_state_t;

    typedef enum logic [6:0] {
        CTL_IDLE  = 7'h01,
        CTL_START = 7'h02,
        CTL_SEND  = 7'h04,
        CTL_ACK   = 7'h08,
        CTL_RECV  = 7'h10,
        CTL_NAK   = 7'h20,
        CTL_STOP  = 7'h40
    } ctl_state_t;
endpackage : wiper_pkg

// file: wiper_link.sv
// Two-wire link between the controller and the wiper target.
// Resolves both open-drain lines with a pull-up; the controller alone drives SCL.
`timescale 1ns/1ps
interface wiper_link;
    logic scl_m_out;
    logic scl_m_oe;
    logic sda_m_out;
    logic sda_m_oe;
    logic sda_d_out;
    logic sda_d_oe;
    logic scl;
    logic sda;

    assign scl = scl_m_oe ? scl_m_out : 1'b1;
    assign sda = (sda_m_oe ? sda_m_out : 1'b1) & (sda_d_oe ? sda_d_out : 1'b1);

    modport host   (output scl_m_out, scl_m_oe, sda_m_out, sda_m_oe, input sda);
    modport device (input scl, sda, output sda_d_out, sda_d_oe);
endinterface : wiper_link

// file: sync2.sv
// Two-flop synchroniser for levels or quasi-static words.
// Assumes a multi-bit input changes only while its consumer is not looking.
`timescale 1ns/1ps
module sync2 #(
    parameter int unsigned W         = 1,
    parameter logic [W-1:0] RESET_VAL = '0
) (
    input  wire logic         clk,
    input  wire logic         reset,
    input  wire logic [W-1:0] d,
    output      logic [W-1:0] q
);
    logic [W-1:0] meta_q;

    always_ff @(posedge clk) begin
        if (reset) begin
            meta_q <= RESET_VAL;
            q      <= RESET_VAL;
        end else begin
            meta_q <= d;
            q      <= meta_q;
        end
    end
endmodule : sync2

// file: wiper_target.sv
// Wiper position target: serial link logic on SCL and the tap register on clk.
// Assumes SCL stands still outside frames and SDA is stable while SCL is high
// except for START and STOP.
//
// Behaviour
// - Seven-bit wiper closes one of 128 taps
// - Wiper loads midscale 40h at reset
// - Write drops data MSB, keeps seven bits
// - Read returns zero MSB then seven bits
// - Master writes: START, address, 00h, data, STOP
// - Acknowledge address, register and data bytes
// - Commit only after third write byte
// - Master reads via repeated START, read address
// - Acknowledge received bytes, then send data byte
// - Master withholds final acknowledge, then STOP
// - First byte: seven-bit identifier plus direction
// - Direction one reads, zero writes
// - Foreign identifier: stay silent, no acknowledge
// - Missing acknowledge: release data, await STOP
`timescale 1ns/1ps
module wiper_target (
    input  wire logic                           clk,
    input  wire logic                           reset,
    wiper_link.device                           link,
    output      logic [wiper_pkg::WIPER_W-1:0]  wiper_position,
    output      logic [wiper_pkg::TAPS-1:0]     tap_select
);
    import wiper_pkg::*;

    tgt_state_t   state_q;
    logic         start_tog_q;
    logic         start_seen_q;
    logic [2:0]   cnt_q;
    logic [6:0]   shift_q;
    logic [7:0]   byte_in;
    logic         rw_q;
    logic         reg_ok_q;
    logic [6:0]   data_q;
    logic         commit_tog_q;
    logic [7:0]   tx_q;
    logic [6:0]   wiper_lnk;
    logic         sda_oe_q;
    logic         sda_out_q;
    logic         commit_s;
    logic         commit_seen_q;
    logic [6:0]   wiper_q;
    logic [127:0] tap_q;

    function automatic logic [127:0] tap_decode(input logic [6:0] pos);
        tap_decode      = '0;
        tap_decode[pos] = 1'b1;
    endfunction : tap_decode

    assign byte_in = {shift_q, link.sda};

    // A falling SDA while SCL is high marks START; the toggle tells the SCL
    // logic a frame has begun. The link clock is absent during reset, so the
    // link-side flops other than the u_wiper_to_link copy take their reset values without it.
    always_ff @(negedge link.sda or posedge reset) begin
        if (reset) begin
            start_tog_q <= 1'b0;
        end else if (link.scl) begin
            start_tog_q <= ~start_tog_q;
        end
    end

    // Bit and byte sequencing, sampled on rising SCL.
    always_ff @(posedge link.scl or posedge reset) begin
        if (reset) begin
            state_q      <= TGT_IDLE;
            start_seen_q <= 1'b0;
            cnt_q        <= 3'h0;
            shift_q      <= 7'h00;
        end else if (start_tog_q != start_seen_q) begin
            start_seen_q <= start_tog_q;
            state_q      <= TGT_ADDR;
            cnt_q        <= 3'h1;
            shift_q      <= {6'h00, link.sda};
        end else begin
            case (state_q)
                TGT_ADDR: begin
                    shift_q <= byte_in[6:0];
                    cnt_q   <= cnt_q + 3'h1;
                    if (cnt_q == BIT_LAST) begin
                        if (byte_in[7:1] == DEVICE_ID) begin
                            state_q <= TGT_ACK_ADDR;
                        end else begin
                            state_q <= TGT_IDLE;
                        end
                    end
                end
                TGT_ACK_ADDR: begin
                    cnt_q <= 3'h0;
                    if (rw_q) begin
                        state_q <= TGT_TX;
                    end else begin
                        state_q <= TGT_REG;
                    end
                end
                TGT_REG: begin
                    shift_q <= byte_in[6:0];
                    cnt_q   <= cnt_q + 3'h1;
                    if (cnt_q == BIT_LAST) begin
                        state_q <= TGT_ACK_REG;
                    end
                end
                TGT_ACK_REG: begin
                    cnt_q   <= 3'h0;
                    state_q <= TGT_DATA;
                end
                TGT_DATA: begin
                    shift_q <= byte_in[6:0];
                    cnt_q   <= cnt_q + 3'h1;
                    if (cnt_q == BIT_LAST) begin
                        state_q <= TGT_ACK_DATA;
                    end
                end
                TGT_ACK_DATA: begin
                    // Further bytes before STOP are ignored and not acknowledged.
                    state_q <= TGT_IDLE;
                end
                TGT_TX: begin
                    cnt_q <= cnt_q + 3'h1;
                    if (cnt_q == BIT_LAST) begin
                        state_q <= TGT_TX_ACK;
                    end
                end
                TGT_TX_ACK: begin
                    cnt_q <= 3'h0;
                    if (link.sda) begin
                        state_q <= TGT_IDLE;
                    end else begin
                        state_q <= TGT_TX;
                    end
                end
                default: begin
                    state_q <= TGT_IDLE;
                end
            endcase
        end
    end

    // Direction and register address captured at the end of their bytes.
    always_ff @(posedge link.scl or posedge reset) begin
        if (reset) begin
            rw_q     <= 1'b0;
            reg_ok_q <= 1'b0;
        end else begin
            if (state_q == TGT_ADDR && cnt_q == BIT_LAST) begin
                rw_q <= byte_in[0];
            end
            if (state_q == TGT_REG && cnt_q == BIT_LAST) begin
                reg_ok_q <= (byte_in == REG_ADDR_WIPER);
            end
        end
    end

    // Received data keeps only its low seven bits.
    always_ff @(posedge link.scl or posedge reset) begin
        if (reset) begin
            data_q <= WIPER_RESET;
        end else if (state_q == TGT_DATA && cnt_q == BIT_LAST) begin
            data_q <= byte_in[6:0];
        end
    end

    // The commit is signalled at the acknowledge clock of the third byte.
    always_ff @(posedge link.scl or posedge reset) begin
        if (reset) begin
            commit_tog_q <= 1'b0;
        end else if (state_q == TGT_ACK_DATA && reg_ok_q) begin
            commit_tog_q <= ~commit_tog_q;
        end
    end

    // Outgoing byte is built when the read address is acknowledged.
    always_ff @(posedge link.scl or posedge reset) begin
        if (reset) begin
            tx_q <= 8'h00;
        end else if (state_q == TGT_ACK_ADDR && rw_q) begin
            tx_q <= {1'b0, wiper_lnk};
        end
    end

    // SDA changes only on falling SCL, so it is stable while SCL is high.
    always_ff @(negedge link.scl or posedge reset) begin
        if (reset) begin
            sda_oe_q <= 1'b0;
        end else begin
            case (state_q)
                TGT_ACK_ADDR, TGT_ACK_REG, TGT_ACK_DATA: begin
                    sda_oe_q <= 1'b1;
                end
                TGT_TX: begin
                    sda_oe_q <= ~tx_q[BIT_LAST - cnt_q];
                end
                default: begin
                    sda_oe_q <= 1'b0;
                end
            endcase
        end
    end

    always_ff @(negedge link.scl or posedge reset) begin
        if (reset) begin
            sda_out_q <= 1'b0;
        end else begin
            sda_out_q <= 1'b0;
        end
    end

    assign link.sda_d_oe  = sda_oe_q;
    assign link.sda_d_out = sda_out_q;

    // The wiper only changes through a commit from this link, long before any
    // read of it, so a plain two-flop copy into the SCL domain is safe.
    sync2 #(
        .W         (WIPER_W),
        .RESET_VAL (WIPER_RESET)
    ) u_wiper_to_link (
        .clk   (link.scl),
        .reset (reset),
        .d     (wiper_q),
        .q     (wiper_lnk)
    );

    sync2 #(
        .W         (1),
        .RESET_VAL (1'b0)
    ) u_commit_to_clk (
        .clk   (clk),
        .reset (reset),
        .d     (commit_tog_q),
        .q     (commit_s)
    );

    // Word data_q is held since before the toggle moved, so it is stable here.
    always_ff @(posedge clk) begin
        if (reset) begin
            commit_seen_q <= 1'b0;
            wiper_q       <= WIPER_RESET;
            tap_q         <= tap_decode(WIPER_RESET);
        end else begin
            commit_seen_q <= commit_s;
            if (commit_s != commit_seen_q) begin
                wiper_q <= data_q;
                tap_q   <= tap_decode(data_q);
            end
        end
    end

    assign wiper_position = wiper_q;
    assign tap_select     = tap_q;
endmodule : wiper_target

// file: wiper_ctrl.sv
// Link controller with an APB register port: writes or reads the target's wiper.
// Assumes a 40 MHz clk; SCL is divided from it and driven open-drain.
`timescale 1ns/1ps
module wiper_ctrl (
    input  wire logic        clk,
    input  wire logic        reset,
    input  wire logic [11:0] paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    output      logic [31:0] prdata,
    output      logic        pready,
    output      logic        pslverr,
    wiper_link.host          link
);
    import wiper_pkg::*;

    ctl_state_t  state_q;
    logic [5:0]  div_q;
    logic [1:0]  qtr_q;
    logic [1:0]  bidx_q;
    logic [2:0]  bit_q;
    logic        tick;
    logic        slot_end;
    logic        sda_s;
    logic        ack_bad_q;
    logic [7:0]  rx_q;
    logic        read_op_q;
    logic [7:0]  wdata_q;
    logic [6:0]  target_q;
    logic        done_q;
    logic        nack_q;
    logic [7:0]  rdata_q;
    logic        wr_en;
    logic        go;
    logic [7:0]  tx_byte;
    logic        scl_oe_q;
    logic        sda_oe_q;
    logic        pins_out_q;
    logic [31:0] prdata_q;
    logic        pready_q;
    logic        pslverr_q;

    assign wr_en    = psel && penable && pready_q && pwrite;
    assign go       = wr_en && paddr == CTRL_OFF && pwdata[CTRL_GO] && state_q == CTL_IDLE;
    assign tick     = div_q == QUARTER_LAST;
    assign slot_end = tick && qtr_q == 2'h3;

    always_comb begin
        case (bidx_q)
            2'h0:    tx_byte = {target_q, 1'b0};
            2'h1:    tx_byte = REG_ADDR_WIPER;
            default: tx_byte = read_op_q ? {target_q, 1'b1} : wdata_q;
        endcase
    end

    sync2 #(
        .W         (1),
        .RESET_VAL (1'b1)
    ) u_sda_sync (
        .clk   (clk),
        .reset (reset),
        .d     (link.sda),
        .q     (sda_s)
    );

    always_ff @(posedge clk) begin
        if (reset || state_q == CTL_IDLE || tick) begin
            div_q <= 6'h00;
        end else begin
            div_q <= div_q + 6'h01;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            state_q <= CTL_IDLE;
            qtr_q   <= 2'h0;
            bidx_q  <= 2'h0;
            bit_q   <= BIT_LAST;
        end else if (go) begin
            state_q <= CTL_START;
            qtr_q   <= 2'h0;
            bidx_q  <= 2'h0;
        end else if (tick) begin
            qtr_q <= qtr_q + 2'h1;
            if (slot_end) begin
                bit_q <= BIT_LAST;
                case (state_q)
                    CTL_START: state_q <= CTL_SEND;
                    CTL_SEND: begin
                        bit_q <= bit_q - 3'h1;
                        if (bit_q == 3'h0) begin
                            state_q <= CTL_ACK;
                        end
                    end
                    CTL_ACK: begin
                        bidx_q <= bidx_q + 2'h1;
                        if (ack_bad_q || bidx_q == 2'h3) begin
                            state_q <= CTL_STOP;
                        end else if (bidx_q == 2'h1 && read_op_q) begin
                            state_q <= CTL_START;
                        end else if (bidx_q == 2'h2) begin
                            state_q <= read_op_q ? CTL_RECV : CTL_STOP;
                        end else begin
                            state_q <= CTL_SEND;
                        end
                    end
                    CTL_RECV: begin
                        bit_q <= bit_q - 3'h1;
                        if (bit_q == 3'h0) begin
                            state_q <= CTL_NAK;
                        end
                    end
                    CTL_NAK:  state_q <= CTL_STOP;
                    default:  state_q <= CTL_IDLE;
                endcase
            end
        end
    end

    // SDA is sampled at the end of the third quarter, midway through SCL high.
    always_ff @(posedge clk) begin
        if (reset) begin
            ack_bad_q <= 1'b0;
            rx_q      <= 8'h00;
        end else if (tick && qtr_q == 2'h2) begin
            if (state_q == CTL_ACK) begin
                ack_bad_q <= sda_s;
            end
            if (state_q == CTL_RECV) begin
                rx_q <= {rx_q[6:0], sda_s};
            end
        end
    end

    // Pin drive: SCL low in the first half of bit slots, SDA set while SCL is low.
    always_ff @(posedge clk) begin
        if (reset) begin
            scl_oe_q   <= 1'b0;
            sda_oe_q   <= 1'b0;
            pins_out_q <= 1'b0;
        end else begin
            pins_out_q <= 1'b0;
            case (state_q)
                CTL_START: begin
                    scl_oe_q <= qtr_q == 2'h0 && bidx_q != 2'h0;
                    sda_oe_q <= qtr_q[1];
                end
                CTL_SEND: begin
                    scl_oe_q <= ~qtr_q[1];
                    // SDA moves a quarter after SCL falls, so the target never sees a false START.
                    if (qtr_q != 2'h0) begin
                        sda_oe_q <= ~tx_byte[bit_q];
                    end
                end
                CTL_ACK, CTL_RECV, CTL_NAK: begin
                    scl_oe_q <= ~qtr_q[1];
                    if (qtr_q != 2'h0) begin
                        sda_oe_q <= 1'b0;
                    end
                end
                CTL_STOP: begin
                    scl_oe_q <= ~qtr_q[1];
                    if (qtr_q != 2'h0) begin
                        sda_oe_q <= qtr_q != 2'h3;
                    end
                end
                default: begin
                    scl_oe_q <= 1'b0;
                    sda_oe_q <= 1'b0;
                end
            endcase
        end
    end

    assign link.scl_m_oe  = scl_oe_q;
    assign link.sda_m_oe  = sda_oe_q;
    assign link.scl_m_out = pins_out_q;
    assign link.sda_m_out = pins_out_q;

    always_ff @(posedge clk) begin
        if (reset) begin
            read_op_q <= 1'b0;
            wdata_q   <= 8'h00;
            target_q  <= DEVICE_ID;
        end else begin
            if (go) begin
                read_op_q <= pwdata[CTRL_READ];
                wdata_q   <= pwdata[CTRL_DATA_LSB +: 8];
            end
            if (wr_en && paddr == TARGET_OFF) begin
                target_q <= pwdata[6:0];
            end
        end
    end

    // A completion in the same cycle as a clear wins over the clear.
    always_ff @(posedge clk) begin
        if (reset) begin
            done_q  <= 1'b0;
            nack_q  <= 1'b0;
            rdata_q <= 8'h00;
        end else if (slot_end && state_q == CTL_STOP) begin
            done_q  <= 1'b1;
            nack_q  <= ack_bad_q;
            rdata_q <= rx_q;
        end else if (go || (wr_en && paddr == STATUS_OFF && pwdata[STAT_DONE])) begin
            done_q <= 1'b0;
            nack_q <= 1'b0;
        end
    end

    // APB: read data and status are registered in the setup cycle; one wait-free access.
    always_ff @(posedge clk) begin
        if (reset) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h0000_0000;
        end else begin
            pready_q  <= psel && !penable;
            pslverr_q <= psel && !penable && paddr != CTRL_OFF && paddr != STATUS_OFF && paddr != TARGET_OFF;
            if (psel && !penable) begin
                case (paddr)
                    CTRL_OFF:   prdata_q <= {16'h0000, wdata_q, 6'h00, read_op_q, 1'b0};
                    STATUS_OFF: prdata_q <= {16'h0000, rdata_q, 5'h00, nack_q, done_q, state_q != CTL_IDLE};
                    TARGET_OFF: prdata_q <= {25'h0, target_q};
                    default:    prdata_q <= 32'h0000_0000;
                endcase
            end
        end
    end

    assign prdata  = prdata_q;
    assign pready  = pready_q;
    assign pslverr = pslverr_q;
endmodule : wiper_ctrl

// file: wiper_link_asserts.sv
// Concurrent checks on the two-wire link between the controller and the wiper target.
// Assumes it is instantiated beside the link, sampling on the controller clock.
`timescale 1ns/1ps
module wiper_link_asserts (
    input wire logic         clk,
    input wire logic         reset,
    input wire logic         sda_m_oe,
    input wire logic         sda_d_out,
    input wire logic         sda_d_oe,
    input wire logic         scl,
    input wire logic         sda,
    input wire logic [6:0]   wiper_position,
    input wire logic [127:0] tap_select
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    chk_tap_one_hot: assert property (tap_select == (128'h1 << wiper_position))
        else $error("tap select is not the decode of the wiper");
    chk_reset_midscale: assert property ($fell(reset) |-> wiper_position == 7'h40 && tap_select[64])
        else $error("wiper not at midscale after reset");
    chk_drive_scl_low: assert property ($changed(sda_d_oe) |-> !scl)
        else $error("target changed its data drive while clock high");
    chk_open_drain_low: assert property (sda_d_oe |-> !sda_d_out)
        else $error("target drives a high level");
    chk_commit_at_ack: assert property ($changed(wiper_position) |-> scl && sda_d_oe)
        else $error("wiper changed outside the data acknowledge");
    chk_ack_held_high: assert property ($rose(scl) && sda_d_oe |-> sda_d_oe [*8])
        else $error("target released data during clock high");
    chk_cond_released: assert property (scl && $past(scl) && $changed(sda) |-> !sda_d_oe && !$past(sda_d_oe))
        else $error("target holds data across a start or stop");
    chk_cond_by_host: assert property (scl && $past(scl) && $changed(sda) |-> $changed(sda_m_oe))
        else $error("data changed while clock high without the host");
endmodule : wiper_link_asserts

// file: wiper_register_i2c_slave_tb.sv
// Self-checking bench: controller and wiper target joined by the link, driven over APB.
// Assumes the controller answers APB in one access cycle and reports completion in STATUS.
`timescale 1ns/1ps
module wiper_register_i2c_slave_tb;
    import wiper_pkg::*;
    logic         clk;
    logic         reset;
    logic [11:0]  paddr;
    logic         psel;
    logic         penable;
    logic         pwrite;
    logic [31:0]  pwdata;
    logic [31:0]  prdata;
    logic         pready;
    logic         pslverr;
    logic [6:0]   wiper_position;
    logic [127:0] tap_select;
    logic [31:0]  rdv;
    logic         errv;
    logic [6:0]   m;
    logic [7:0]   vals [3];
    int           fails;
    int           checked;
    int           cycles;
    int           seed;

    wiper_link link ();
    wiper_ctrl wiper_ctrl_inst (.clk(clk), .reset(reset), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .link(link));
    wiper_target wiper_target_inst (.clk(clk), .reset(reset), .link(link), .wiper_position(wiper_position),
        .tap_select(tap_select));
    wiper_link_asserts wiper_link_asserts_inst (.clk(clk), .reset(reset), .sda_m_oe(link.sda_m_oe),
        .sda_d_out(link.sda_d_out), .sda_d_oe(link.sda_d_oe), .scl(link.scl), .sda(link.sda),
        .wiper_position(wiper_position), .tap_select(tap_select));

    always #12.5 clk = ~clk;

    function automatic logic [7:0] exp_read(input logic [6:0] w);
        return {1'b0, w};
    endfunction : exp_read

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
            fails++;
        end
    endtask : chk

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rdv = prdata;
        errv = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // Starts one frame and polls until the controller reports it finished.
    task automatic xfer(input logic rd_op, input logic [7:0] d);
        apb(1'b1, CTRL_OFF, {16'h0, d, 6'h0, rd_op, 1'b1});
        do apb(1'b0, STATUS_OFF, 32'h0);
        while (!(rdv[STAT_DONE] === 1'b1 && rdv[STAT_BUSY] === 1'b0));
    endtask : xfer

    task automatic final_report;
        $display("comparisons %0d mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : final_report

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 80000) begin
            fails++;
            final_report();
        end
    end

    initial begin
        clk = 1'b0;
        reset = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        fails = 0;
        checked = 0;
        cycles = 0;
        seed = 32'hb104e391;
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        m = 7'h40;
        chk({25'h0, wiper_position}, {25'h0, m});
        chk({31'h0, tap_select === (128'h1 << m)}, 32'h1);
        apb(1'b0, TARGET_OFF, 32'h0);
        chk(rdv, {25'h0, DEVICE_ID});
        xfer(1'b1, 8'h00);
        chk({24'h0, rdv[15:8]}, {24'h0, exp_read(m)});
        $display("test power_up done");
        vals[0] = 8'hff;
        vals[1] = 8'h80;
        vals[2] = 8'($random(seed));
        for (int i = 0; i < 3; i++) begin
            xfer(1'b0, vals[i]);
            chk({31'h0, rdv[STAT_NACK]}, 32'h0);
            m = vals[i][6:0];
            chk({25'h0, wiper_position}, {25'h0, m});
            chk({31'h0, tap_select === (128'h1 << m)}, 32'h1);
            xfer(1'b1, 8'h00);
            chk({31'h0, rdv[STAT_NACK]}, 32'h0);
            chk({24'h0, rdv[15:8]}, {24'h0, exp_read(m)});
        end
        $display("test write_read done");
        apb(1'b1, TARGET_OFF, {25'h0, DEVICE_ID ^ 7'h01});
        xfer(1'b0, 8'h15);
        chk({31'h0, rdv[STAT_NACK]}, 32'h1);
        chk({25'h0, wiper_position}, {25'h0, m});
        apb(1'b1, TARGET_OFF, {25'h0, DEVICE_ID});
        $display("test foreign_id done");
        apb(1'b0, 12'h00c, 32'h0);
        chk({31'h0, errv}, 32'h1);
        chk(rdv, 32'h0);
        $display("test unmapped done");
        reset <= 1'b1;
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        chk({25'h0, wiper_position}, {25'h0, WIPER_RESET});
        chk({31'h0, tap_select === (128'h1 << WIPER_RESET)}, 32'h1);
        xfer(1'b1, 8'h00);
        chk({24'h0, rdv[15:8]}, {24'h0, exp_read(WIPER_RESET)});
        $display("test second_reset done");
        final_report();
    end
endmodule : wiper_register_i2c_slave_tb
